//--- logic/tpt_defines.vh
// tpt_defines.vh: register indices, control-word layout and reset values
// for the triple programmable timer.
// assumes inclusion by bare name from the timer design file.
`ifndef TPT_DEFINES_VH
`define TPT_DEFINES_VH

// register index (word address on the bus) of each timer's first register
`define TPT_T0_BASE     8'h50
`define TPT_T1_BASE     8'h58
`define TPT_T2_BASE     8'h60
// per-timer register index offsets
`define TPT_OFS_CNT     8'h00
`define TPT_OFS_MAXA    8'h02
`define TPT_OFS_MAXB    8'h04
`define TPT_OFS_CTL     8'h06

// control word bit positions
`define TPT_B_EN        15
`define TPT_B_MASK      14
`define TPT_B_INT       13
`define TPT_B_ACTLIM    12
`define TPT_B_LIMHIT    5
`define TPT_B_RTG       4
`define TPT_B_PRE       3
`define TPT_B_OUTCLK    2
`define TPT_B_DUAL      1
`define TPT_B_FREE      0

// reset values and constants
`define TPT_RST16       16'h0000
`define TPT_ONE16       16'h0001
`define TPT_ZERO6       6'h00
`define TPT_SLOT_RST    2'h0
`define TPT_SLOT_ONE    2'h1
`define TPT_DATA_PAD    16'h0000

`endif

//--- logic/tpt_timers.v
// tpt_timers.v: three 16-bit programmable timers with an Avalon-MM slave.
// assumes one 200 MHz clock, asynchronous active-low reset, event pins that
// may be asynchronous, and an interrupt controller that latches the pulses.
`include "tpt_defines.vh"
`default_nettype none

module tpt_timers #(
  parameter integer N_TMR = 3
) (
  input  wire        i_ref_clk,
  input  wire        i_rstn,
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output wire        o_avs_waitrequest,
  output reg  [31:0] o_avs_readdata,
  input  wire [1:0]  i_tmr_in,
  output wire [1:0]  o_tmr_out,
  output wire [2:0]  o_tmr_irq
);

  // base index of a timer's register group
  function [7:0] tpt_base;
    input integer k;
    begin
      if (k == 0) begin
        tpt_base = `TPT_T0_BASE;
      end else if (k == 1) begin
        tpt_base = `TPT_T1_BASE;
      end else begin
        tpt_base = `TPT_T2_BASE;
      end
    end
  endfunction

  reg        ack_q;
  reg  [1:0] slot_q;
  wire       req;
  wire       wr_go;
  wire [15:0] wdata;
  wire [47:0] cnt_all;
  wire [47:0] maxa_all;
  wire [47:0] maxb_all;
  wire [47:0] ctl_all;
  wire [2:0]  term_all;
  wire [2:0]  out_all;
  wire [2:0]  irq_all;
  reg  [31:0] rd_d;
  integer     k;

  // one wait state on every access: the slave answers on the second edge.
  // the ack flop alternates for each access, so a master that keeps its
  // request up past the answer edge starts a second access; masters must
  // drop or change the request right after the answer.
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_go             = i_avs_write & ack_q;
  assign wdata             = i_avs_writedata[15:0];
  assign o_tmr_out         = out_all[1:0];
  assign o_tmr_irq         = irq_all;

  // access phase flop and round-robin service slot.
  // slot 3 is left idle, so each timer is visited once every four clocks;
  // that visit rate is the fastest any timer can advance.
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_q  <= 1'b0;
      slot_q <= `TPT_SLOT_RST;
    end else begin
      ack_q  <= req & ~ack_q;
      slot_q <= slot_q + `TPT_SLOT_ONE;
    end
  end

  // read mux; unmapped indices and the missing timer-2 limit B read zero.
  // the loop walks every timer group; the groups never overlap, so at
  // most one branch can match for a given index.
  always @* begin
    rd_d = {`TPT_DATA_PAD, `TPT_RST16};
    for (k = 0; k < N_TMR; k = k + 1) begin
      if (i_avs_address == tpt_base(k) + `TPT_OFS_CNT) begin
        rd_d = {`TPT_DATA_PAD, cnt_all[16*k +: 16]};
      end else if (i_avs_address == tpt_base(k) + `TPT_OFS_MAXA) begin
        rd_d = {`TPT_DATA_PAD, maxa_all[16*k +: 16]};
      end else if (i_avs_address == tpt_base(k) + `TPT_OFS_MAXB) begin
        rd_d = {`TPT_DATA_PAD, maxb_all[16*k +: 16]};
      end else if (i_avs_address == tpt_base(k) + `TPT_OFS_CTL) begin
        rd_d = {`TPT_DATA_PAD, ctl_all[16*k +: 16]};
      end
    end
  end

  // read data is captured in the wait cycle and stands at the answer edge.
  // loading only once keeps the word steady even if a count moves between
  // the wait cycle and the answer edge.
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= {`TPT_DATA_PAD, `TPT_RST16};
    end else if (i_avs_read & ~ack_q) begin
      o_avs_readdata <= rd_d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N_TMR; i = i + 1) begin : g_tmr
      // timer 2 has no pin, no second limit and fixed mode bits; its hits
      // also feed the prescaler input of timers 0 and 1
      localparam FULL = (i < 2);
      localparam [7:0] BASE = (i == 0) ? `TPT_T0_BASE :
                              (i == 1) ? `TPT_T1_BASE : `TPT_T2_BASE;
      // service slot of this timer, cut on purpose to the slot width
      localparam [31:0] SLOT_W = i;
      localparam [1:0] MYSLOT = SLOT_W[1:0];

      reg [15:0] cnt_q;
      reg [15:0] maxa_q;
      reg [15:0] maxb_q;
      reg        en_q;
      reg        int_q;
      reg        actlim_q;
      reg        limhit_q;
      reg        rtg_q;
      reg        pre_q;
      reg        outclk_q;
      reg        dual_q;
      reg        free_q;
      reg        sync1_q;
      reg        sync2_q;
      reg        sync3_q;
      reg        edge_q;
      reg        t2tick_q;
      reg        started_q;
      reg        out_q;
      reg        irq_q;
      wire       pin_lvl;
      wire       pin_rise;
      wire       edge_now;
      wire       tick;
      wire       base_ev;
      wire       restart;
      wire       ev;
      wire [15:0] nxt;
      wire [15:0] lim;
      wire       term;
      wire       halt;
      wire       actlim_n;
      wire       wr_cnt;
      wire       wr_maxa;
      wire       wr_maxb;
      wire       wr_ctl;

      assign wr_cnt  = wr_go & (i_avs_address == BASE + `TPT_OFS_CNT);
      assign wr_maxa = wr_go & (i_avs_address == BASE + `TPT_OFS_MAXA);
      assign wr_maxb = wr_go & (i_avs_address == BASE + `TPT_OFS_MAXB) &
                       FULL;
      assign wr_ctl  = wr_go & (i_avs_address == BASE + `TPT_OFS_CTL);

      // pin synchroniser: sync1 feeds only sync2, edges judged one stage on.
      // sync1 may settle late, so nothing else reads it. a pin held high
      // through reset shows one rise after it, dropped while still disabled.
      // timer 2 keeps the same flops tied low so the slices stay alike.
      if (FULL) begin : g_pin
        always @(posedge i_ref_clk or negedge i_rstn) begin
          if (!i_rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
          end else begin
            sync1_q <= i_tmr_in[i];
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
          end
        end
        assign pin_lvl  = sync2_q;
        assign pin_rise = sync2_q & ~sync3_q;
      end else begin : g_nopin
        always @(posedge i_ref_clk or negedge i_rstn) begin
          if (!i_rstn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
          end else begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
          end
        end
        assign pin_lvl  = 1'b1;
        assign pin_rise = 1'b0;
      end

      assign tick    = (slot_q == MYSLOT) & en_q;
      // a rise seen in the slot's own clock is used at once, else it waits;
      // this keeps pin-to-output within six clocks in the worst phase
      assign edge_now = edge_q | pin_rise;
      // internal rate is the service slot itself, or a held timer-2 hit
      assign base_ev = pre_q ? t2tick_q : 1'b1;
      assign restart = ~outclk_q & rtg_q & edge_now;
      assign ev      = outclk_q ? edge_now :
                       rtg_q    ? (started_q & base_ev) :
                                  (pin_lvl & base_ev);
      assign nxt     = cnt_q + `TPT_ONE16;
      assign lim     = actlim_q ? maxb_q : maxa_q;
      // equality only, so a count above the limit wraps through zero
      assign term    = tick & ev & ~restart & (nxt == lim);
      // one-shot stops after A, or after A then B in dual mode
      assign halt    = term & ~free_q & (~dual_q | actlim_q);
      assign actlim_n = ~dual_q ? 1'b0 :
                        (term ? ~actlim_q : actlim_q);

      // pin edge pending until the next service slot. the slot always
      // clears it: a rise in that same clock is consumed directly through
      // edge_now, so no edge is counted twice and none is lost while rises are at least four clocks apart.
      // the timer-2 hit is a different slot, so there set wins over clear
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          edge_q    <= 1'b0;
          t2tick_q  <= 1'b0;
          started_q <= 1'b0;
        end else if (!en_q) begin
          edge_q    <= 1'b0;
          t2tick_q  <= 1'b0;
          started_q <= 1'b0;
        end else begin
          if (slot_q == MYSLOT) begin
            edge_q <= 1'b0;
          end else if (pin_rise) begin
            edge_q <= 1'b1;
          end
          if (term_all[2]) begin
            t2tick_q <= 1'b1;
          end else if (slot_q == MYSLOT) begin
            t2tick_q <= 1'b0;
          end
          if (tick & restart) begin
            started_q <= 1'b1;
          end
        end
      end

      // count: a bus write wins in its own cycle.
      // software may move the phase of a running timer this way; a restart
      // edge outranks the normal step so the count really starts at zero.
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_q <= `TPT_RST16;
        end else if (wr_cnt) begin
          cnt_q <= wdata;
        end else if (tick & restart) begin
          cnt_q <= `TPT_RST16;
        end else if (tick & ev) begin
          cnt_q <= term ? `TPT_RST16 : nxt;
        end
      end

      // limit registers; timer 2 keeps limit B at zero.
      // no check against the count here: a limit below the count is legal,
      // the count then runs on and wraps through zero.
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          maxa_q <= `TPT_RST16;
          maxb_q <= `TPT_RST16;
        end else begin
          if (wr_maxa) begin
            maxa_q <= wdata;
          end
          if (wr_maxb) begin
            maxb_q <= wdata;
          end
        end
      end

      // control word.
      // enable is the only field guarded by the mask bit. a masked write
      // beats the automatic halt in the same clock, so software intent is
      // never lost; the fixed timer-2 bits are forced low at the write.
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          en_q     <= 1'b0;
          int_q    <= 1'b0;
          rtg_q    <= 1'b0;
          pre_q    <= 1'b0;
          outclk_q <= 1'b0;
          dual_q   <= 1'b0;
          free_q   <= 1'b0;
        end else begin
          if (wr_ctl & wdata[`TPT_B_MASK]) begin
            en_q <= wdata[`TPT_B_EN];
          end else if (halt) begin
            en_q <= 1'b0;
          end
          if (wr_ctl) begin
            int_q    <= wdata[`TPT_B_INT];
            free_q   <= wdata[`TPT_B_FREE];
            rtg_q    <= wdata[`TPT_B_RTG] & FULL;
            pre_q    <= wdata[`TPT_B_PRE] & FULL;
            outclk_q <= wdata[`TPT_B_OUTCLK] & FULL;
            dual_q   <= wdata[`TPT_B_DUAL] & FULL;
          end
        end
      end

      // status flags: a hit in the clearing cycle keeps the flag set.
      // the active-limit flag follows only hardware, never the bus data,
      // and drops one clock after dual-limit mode is switched off.
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          actlim_q <= 1'b0;
          limhit_q <= 1'b0;
        end else begin
          actlim_q <= actlim_n;
          if (term) begin
            limhit_q <= 1'b1;
          end else if (wr_ctl & ~wdata[`TPT_B_LIMHIT]) begin
            limhit_q <= 1'b0;
          end
        end
      end

      // output pin and request pulse, both from flops.
      // both move at the same slot edge as the count, so the pin and the
      // request line never disagree about which hit they belong to.
      always @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          out_q <= 1'b1;
          irq_q <= 1'b0;
        end else begin
          out_q <= dual_q ? ~actlim_n : ~term;
          // a pulse once sent is the controller's to hold
          irq_q <= term & int_q;
        end
      end

      assign cnt_all[16*i +: 16]  = cnt_q;
      assign maxa_all[16*i +: 16] = maxa_q;
      assign maxb_all[16*i +: 16] = maxb_q;
      // mask bit and undefined bits read as zero
      assign ctl_all[16*i +: 16]  = {en_q, 1'b0, int_q, actlim_q,
                                     `TPT_ZERO6, limhit_q, rtg_q,
                                     pre_q, outclk_q, dual_q, free_q};
      assign term_all[i] = term;
      assign out_all[i]  = out_q;
      assign irq_all[i]  = irq_q;
    end
  endgenerate

endmodule // tpt_timers

`default_nettype wire

//--- sim/tpt_timers_assertions.sv
// tpt_timers_assertions.sv: port checker for the triple timer block.
// assumes it is bound to tpt_timers and sees only that module's ports.
`default_nettype none
module tpt_chk #(
  parameter integer N_TMR = 3
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic [31:0] o_avs_readdata,
  input wire logic [1:0]  o_tmr_out,
  input wire logic [2:0]  o_tmr_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_ok, wr_ok, ctl;
  logic [1:0] dual_q;
  // reads and writes land only at the edge with waitrequest low
  assign rd_ok = i_avs_read & ~o_avs_waitrequest;
  assign wr_ok = i_avs_write & ~o_avs_waitrequest;
  assign ctl = i_avs_address inside {8'h56, 8'h5E, 8'h66};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // shadow of the dual-limit bits, since no port shows the mode
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      dual_q <= 2'h0;
    else if (wr_ok && i_avs_address == 8'h56)
      dual_q[0] <= i_avs_writedata[1];
    else if (wr_ok && i_avs_address == 8'h5E)
      dual_q[1] <= i_avs_writedata[1];
  end
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  bus_wait_a: assert property ($rose(i_avs_read | i_avs_write) |->
    s_one_wait) else $error("access wait state wrong");
  reset_out_a: assert property ($rose(i_rstn) |->
    o_tmr_out == 2'h3 && o_tmr_irq == 3'h0) else $error("outputs not idle");
  mask_zero_a: assert property (rd_ok && ctl |->
    !o_avs_readdata[14]) else $error("mask bit read as one");
  undef_zero_a: assert property (rd_ok && ctl |->
    o_avs_readdata[11:6] == 6'h00) else $error("unused bits not zero");
  t2_fixed_a: assert property (rd_ok && i_avs_address == 8'h66 |->
    o_avs_readdata[4:1] == 4'h0) else $error("timer 2 fixed bits set");
  no_lim_b_a: assert property (rd_ok && i_avs_address == 8'h64 |->
    o_avs_readdata == 32'h0) else $error("timer 2 limit B present");
  act_clear_a: assert property (rd_ok && i_avs_address == 8'h56 &&
    !dual_q[0] |-> !o_avs_readdata[12]) else $error("active flag set");
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    irq_gap_a: assert property (o_tmr_irq[i] |=> !o_tmr_irq[i] [*3])
      else $error("timer served too often");
  end
  for (genvar i = 0; i < 2; i++) begin : g_out
    pulse_one_a: assert property (
      $fell(o_tmr_out[i]) && !dual_q[i] |=> o_tmr_out[i])
      else $error("output pulse not one clock");
  end
endmodule // tpt_chk
bind tpt_timers tpt_chk #(.N_TMR(N_TMR)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_avs_readdata(o_avs_readdata), .o_tmr_out(o_tmr_out),
  .o_tmr_irq(o_tmr_irq));
`default_nettype wire

//--- sim/tpt_pin_model.sv
// tpt_pin_model.sv: event and gate source for the two timer input pins.
// assumes the bench calls its tasks; pins move just after rising edges.
`default_nettype none
module tpt_pin_model (
  input  wire logic       i_ref_clk,
  output var  logic [1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pin = 2'h0;
  // hold a gate level until told otherwise
  task automatic level(input int ch, input logic lvl);
    @(posedge i_ref_clk);
    o_pin[ch] <= lvl;
  endtask
  // n rising edges one gap apart, high two clocks each; faster than four
  // clocks the timer may merge edges, so the gap is clamped
  task automatic pulses(input int ch, input int cnt, input int gap);
    if (gap < 4) gap = 4;
    repeat (cnt) begin
      @(posedge i_ref_clk);
      o_pin[ch] <= 1'h1;
      repeat (2) @(posedge i_ref_clk);
      o_pin[ch] <= 1'h0;
      repeat (gap - 3) @(posedge i_ref_clk);
    end
  endtask
endmodule // tpt_pin_model
`default_nettype wire

//--- sim/testbench.sv
// testbench.sv: register-level tests of the triple timer block.
// assumes tpt_timers, the pin model and the bound port checker.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, rd, wr, wreq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  pin, tout;
  logic [2:0]  irq;
  logic [15:0] v;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n, t0;
  tpt_timers #(.N_TMR(3)) u_dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_waitrequest(wreq), .o_avs_readdata(rdata),
    .i_tmr_in(pin), .o_tmr_out(tout), .o_tmr_irq(irq));
  tpt_pin_model u_pins (.i_ref_clk(clk), .o_pin(pin));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // hang guard: the tests need some five hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access: held until a rising edge samples waitrequest low; read
  // data is taken at that edge and the request dropped right after it
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (wreq !== 1'h0);
    v = rdata[15:0];
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic wrw(input logic [7:0] a, input logic [15:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 16'h0000);
    chk(v, e);
  endtask
  // wait for a request pulse (sel 1) or an output level (sel 0)
  task automatic await(input logic sel, input int ch, input logic lvl);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? irq[ch] : tout[ch]) !== lvl && n < 100);
    chk({15'h0, n < 100}, 16'h0001);
  endtask
  initial begin
    rstn = 1'h0;
    rd = 1'h0;
    wr = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    chk({14'h0, tout}, 16'h0003);
    rdc(8'h56, 16'h0000);
    wrw(8'h56, 16'h8000);
    rdc(8'h56, 16'h0000);
    wrw(8'h56, 16'hCFC0);
    rdc(8'h56, 16'h8000);
    // timer 0 single limit 3, gated on: one hit every twelve clocks
    wrw(8'h52, 16'h0003);
    wrw(8'h50, 16'h0000);
    wrw(8'h56, 16'hE001);
    u_pins.level(0, 1'h1);
    await(1'h1, 0, 1'h1);
    t0 = cyc;
    await(1'h1, 0, 1'h1);
    chk(16'(cyc - t0), 16'd12);
    await(1'h0, 0, 1'h0);
    @(negedge clk);
    chk({15'h0, tout[0]}, 16'h0001);
    u_pins.level(0, 1'h0);
    repeat (12) @(posedge clk);
    bus(1'h0, 8'h50, 16'h0000);
    repeat (20) @(posedge clk);
    rdc(8'h50, v);
    rdc(8'h56, 16'hA021);
    wrw(8'h56, 16'h2001);
    rdc(8'h56, 16'hA001);
    // timer 1 dual one-shot: out low on limit B, halt after B
    wrw(8'h5A, 16'h0002);
    wrw(8'h5C, 16'h0003);
    wrw(8'h58, 16'h0000);
    u_pins.level(1, 1'h1);
    wrw(8'h5E, 16'hC002);
    await(1'h0, 1, 1'h0);
    t0 = cyc;
    await(1'h0, 1, 1'h1);
    chk(16'(cyc - t0), 16'd12);
    repeat (30) @(posedge clk);
    rdc(8'h5E, 16'h0022);
    rdc(8'h58, 16'h0000);
    // timer 0 on outside clock, then stopped while pulses go on
    wrw(8'h52, 16'h0000);
    wrw(8'h50, 16'h0000);
    wrw(8'h56, 16'hC005);
    u_pins.pulses(0, 10, 4);
    repeat (8) @(posedge clk);
    rdc(8'h50, 16'h000A);
    wrw(8'h56, 16'h4005);
    u_pins.pulses(0, 5, 7);
    rdc(8'h50, 16'h000A);
    // retrigger: idle until the first edge, zeroed by the next
    wrw(8'h56, 16'hC011);
    repeat (20) @(posedge clk);
    rdc(8'h50, 16'h000A);
    u_pins.level(0, 1'h1);
    repeat (40) @(posedge clk);
    bus(1'h0, 8'h50, 16'h0000);
    chk({15'h0, v > 16'h5 && v < 16'hC}, 16'h0001);
    u_pins.level(0, 1'h0);
    repeat (3) @(posedge clk);
    u_pins.level(0, 1'h1);
    repeat (8) @(posedge clk);
    bus(1'h0, 8'h50, 16'h0000);
    chk({15'h0, v < 16'h5}, 16'h0001);
    // timer 2: above its limit it counts on; fixed bits; no limit B
    wrw(8'h62, 16'h0003);
    wrw(8'h60, 16'h0005);
    wrw(8'h66, 16'hC01F);
    rdc(8'h66, 16'h8001);
    wrw(8'h64, 16'h1234);
    rdc(8'h64, 16'h0000);
    repeat (20) @(posedge clk);
    bus(1'h0, 8'h60, 16'h0000);
    chk({15'h0, v > 16'h5}, 16'h0001);
    // timer 2 limit 2 as prescaler of timer 0: one step per 8 clocks
    wrw(8'h62, 16'h0002);
    wrw(8'h60, 16'h0000);
    wrw(8'h50, 16'h0000);
    wrw(8'h56, 16'hC009);
    repeat (80) @(posedge clk);
    bus(1'h0, 8'h50, 16'h0000);
    chk({15'h0, v > 16'h7 && v < 16'hD}, 16'h0001);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
